// ==== adcsc_consts.svh ====
`ifndef ADCSC_CONSTS_SVH
`define ADCSC_CONSTS_SVH

// Register byte offsets
`define ADCSC_OFF_MODE      6'h00
`define ADCSC_OFF_CHSEL     6'h04
`define ADCSC_OFF_RESULT    6'h08
`define ADCSC_OFF_IRQ_STAT  6'h0c
`define ADCSC_OFF_IRQ_CLR   6'h10
`define ADCSC_OFF_IRQ_EN    6'h14
`define ADCSC_OFF_STATUS    6'h18
`define ADCSC_OFF_HIST      6'h20

// Mode register fields
`define ADCSC_MODE_EN_BIT   0
`define ADCSC_MODE_ST_BIT   1
`define ADCSC_MODE_SEL_LO   2
`define ADCSC_MODE_SEL_HI   3

// Interrupt status bits
`define ADCSC_IRQ_END_BIT   0
`define ADCSC_IRQ_EARLY_BIT 1

// Reset values
`define ADCSC_MODE_RST      4'h0
`define ADCSC_CHSEL_RST     2'h0
`define ADCSC_IRQ_EN_RST    2'h0

// Timing
`define ADCSC_CLK_NS        8
`define ADCSC_SETTLE_NS     14000
`define ADCSC_SETTLE_CYC    ((`ADCSC_SETTLE_NS + `ADCSC_CLK_NS - 1) / `ADCSC_CLK_NS)
`define ADCSC_START_DLY_CYC 16
`define ADCSC_BIT_CYC_BASE  6'h04
`define ADCSC_RES_BITS      10

`endif

// ==== adcsc_pkg.sv ====
package adcsc_pkg;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ADCSC_IDLE,
    ADCSC_DELAY,
    ADCSC_SAMPLE,
    ADCSC_CONVERT
  } adcsc_state_e;

  // Software-written converter control
  typedef struct packed {
    logic [1:0] speed;
    logic       start;
    logic       enable;
  } adcsc_mode_s;

  // Result waiting to be committed
  typedef struct packed {
    logic       valid;
    logic       early;
    logic [9:0] data;
  } adcsc_pend_s;

endpackage

// ==== adcsc_hist_mem.sv ====
`timescale 1ns/10ps
// Per-channel result history, registered read port
module adcsc_hist_mem
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_idx,
  input  wire logic [9:0] wr_data,
  input  wire logic [1:0] rd_idx,
  output logic      [9:0] rd_data
);

  logic [9:0] mem [0:3];

  ////////////////////////////////////////////////////////////////////////////
  // Storage array, no reset needed for data
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
  end

  // Read data leaves through a flop
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rd_data <= 10'h000;
    else
      rd_data <= mem[rd_idx];
  end

endmodule // adcsc_hist_mem

// ==== adcsc_top.sv ====
`timescale 1ns/10ps
`include "adcsc_consts.svh"
// What this block does
// - Channel write never clears end flag
// - Old-channel result may land before rewrite
// - Start before settle flags first result
// - Result read during control write undefined
// - Sampling time follows mode; start delay
// - Sampling lasts one sixth of conversion
// - Result read finishes before new store
// - Control write at end suppresses result
module adcsc_top
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cmp_in,
  output logic [1:0]       chan_sel,
  output logic             sample_en,
  output logic [9:0]       dac_code,
  output logic             conv_end_interrupt,
  output logic             irq
);

  // Bit-step length in cycles for a speed setting
  function automatic logic [5:0] bit_cyc(input logic [1:0] speed);
    bit_cyc = `ADCSC_BIT_CYC_BASE << speed;
  endfunction

  adcsc_pkg::adcsc_mode_s  converter_mode_reg, next_mode;
  adcsc_pkg::adcsc_pend_s  pend, next_pend;
  adcsc_pkg::adcsc_state_e state, next_state;
  logic [1:0]  channel_select_reg, next_chsel;
  logic [9:0]  conv_result_reg, next_result;
  logic [1:0]  irq_stat, next_irq_stat, irq_en, next_irq_en;
  logic        res_early, next_res_early, next_cei, next_irq;
  logic [5:0]  aw_addr, next_aw_addr, ar_addr, next_ar_addr;
  logic [31:0] w_data, next_w_data, next_rdata;
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic        next_bvalid, rd_wait, next_rd_wait, next_rvalid;
  logic [6:0]  cnt, next_cnt;
  logic [3:0]  bit_idx, next_bit_idx;
  logic [9:0]  next_dac;
  logic        next_sample;
  logic [10:0] settle_cnt, next_settle_cnt;
  logic        early_start, next_early_start;
  logic [9:0]  hist_rd;
  logic        wr_fire, ctl_wr, res_rd_busy, done_evt, commit;
  logic [9:0]  done_code;

  ////////////////////////////////////////////////////////////////////////////
  // Bus strobes shared by all groups
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign ctl_wr = wr_fire && (aw_addr == `ADCSC_OFF_MODE ||
                              aw_addr == `ADCSC_OFF_CHSEL);
  // Result read is busy from address accept to data hand-off
  assign res_rd_busy =
    (s_axi_arvalid && s_axi_arready &&
     s_axi_araddr == `ADCSC_OFF_RESULT) ||
    ((rd_wait || s_axi_rvalid) && ar_addr == `ADCSC_OFF_RESULT);
  assign commit = pend.valid && !res_rd_busy;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_bvalid  = s_axi_bvalid;
    next_rd_wait = 1'b0;
    next_rvalid  = s_axi_rvalid;
    next_ar_addr = ar_addr;
    next_rdata   = s_axi_rdata;
    next_mode    = converter_mode_reg;
    next_chsel   = channel_select_reg;
    next_irq_en  = irq_en;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      // Only the low byte carries control bits
      if (s_axi_wstrb[0])
      begin
        case (aw_addr)
          `ADCSC_OFF_MODE:
            next_mode = w_data[`ADCSC_MODE_SEL_HI:`ADCSC_MODE_EN_BIT];
          `ADCSC_OFF_CHSEL:
            next_chsel = w_data[1:0];
          `ADCSC_OFF_IRQ_EN:
            next_irq_en = w_data[1:0];
          default:
            next_chsel = next_chsel;
        endcase
      end
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rd_wait = 1'b1;
      next_ar_addr = s_axi_araddr;
    end
    // Second stage: history memory data now valid
    if (rd_wait)
    begin
      next_rvalid = 1'b1;
      case (ar_addr)
        `ADCSC_OFF_MODE:     next_rdata = {28'h0, converter_mode_reg};
        `ADCSC_OFF_CHSEL:    next_rdata = {30'h0, channel_select_reg};
        `ADCSC_OFF_RESULT:   next_rdata = {22'h0, conv_result_reg};
        `ADCSC_OFF_IRQ_STAT: next_rdata = {30'h0, irq_stat};
        `ADCSC_OFF_IRQ_EN:   next_rdata = {30'h0, irq_en};
        `ADCSC_OFF_STATUS:
          next_rdata = {28'h0, res_early, settle_cnt ==
                        11'(`ADCSC_SETTLE_CYC), pend.valid,
                        state != adcsc_pkg::ADCSC_IDLE};
        `ADCSC_OFF_HIST, 6'h24, 6'h28, 6'h2c:
          next_rdata = {22'h0, hist_rd};
        default:             next_rdata = 32'h0;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  // Bus registers; unmapped reads return zero with OKAY
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held            <= 1'b0;
      w_held             <= 1'b0;
      aw_addr            <= 6'h00;
      w_data             <= 32'h0;
      s_axi_bvalid       <= 1'b0;
      rd_wait            <= 1'b0;
      s_axi_rvalid       <= 1'b0;
      ar_addr            <= 6'h00;
      s_axi_rdata        <= 32'h0;
      converter_mode_reg <= `ADCSC_MODE_RST;
      channel_select_reg <= `ADCSC_CHSEL_RST;
      irq_en             <= `ADCSC_IRQ_EN_RST;
    end
    else
    begin
      aw_held            <= next_aw_held;
      w_held             <= next_w_held;
      aw_addr            <= next_aw_addr;
      w_data             <= next_w_data;
      s_axi_bvalid       <= next_bvalid;
      rd_wait            <= next_rd_wait;
      s_axi_rvalid       <= next_rvalid;
      ar_addr            <= next_ar_addr;
      s_axi_rdata        <= next_rdata;
      converter_mode_reg <= next_mode;
      channel_select_reg <= next_chsel;
      irq_en             <= next_irq_en;
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !rd_wait && !s_axi_rvalid;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rresp   = 2'h0;

  adcsc_hist_mem u_hist
  (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (commit),
    .wr_idx   (channel_select_reg),
    .wr_data  (pend.data),
    .rd_idx   (next_ar_addr[3:2]), // Look up at accept, ready next cycle
    .rd_data  (hist_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Final code: last trial bit kept or dropped by the comparator
  assign done_code = cmp_in ? dac_code : (dac_code & ~10'h001);
  assign done_evt = state == adcsc_pkg::ADCSC_CONVERT &&
                    bit_idx == 4'h0 && cnt == 7'h00;

  // Sequencer: delay, sample for two bit-steps, then ten bit-steps
  always_comb
  begin
    next_state       = state;
    next_cnt         = cnt;
    next_bit_idx     = bit_idx;
    next_dac         = dac_code;
    next_early_start = early_start;
    next_settle_cnt  = settle_cnt;
    // Settle window restarts every time the converter is disabled
    if (!converter_mode_reg.enable)
      next_settle_cnt = 11'h000;
    else if (settle_cnt != 11'(`ADCSC_SETTLE_CYC))
      next_settle_cnt = settle_cnt + 11'h001;
    case (state)
      adcsc_pkg::ADCSC_IDLE:
        if (converter_mode_reg.start)
        begin
          next_state = adcsc_pkg::ADCSC_DELAY;
          next_cnt   = 7'(`ADCSC_START_DLY_CYC - 1);
          // Started too early or while disabled
          next_early_start = !converter_mode_reg.enable ||
            settle_cnt != 11'(`ADCSC_SETTLE_CYC);
        end
      adcsc_pkg::ADCSC_DELAY:
        if (cnt == 7'h00)
        begin
          next_state = adcsc_pkg::ADCSC_SAMPLE;
          next_cnt   = {bit_cyc(converter_mode_reg.speed), 1'b0} - 7'h01;
        end
        else
          next_cnt = cnt - 7'h01;
      adcsc_pkg::ADCSC_SAMPLE:
        if (cnt == 7'h00)
        begin
          next_state   = adcsc_pkg::ADCSC_CONVERT;
          next_bit_idx = 4'h9;
          next_dac     = 10'h200;
          next_cnt     = {1'b0, bit_cyc(converter_mode_reg.speed)} - 7'h01;
        end
        else
          next_cnt = cnt - 7'h01;
      adcsc_pkg::ADCSC_CONVERT:
        if (cnt != 7'h00)
          next_cnt = cnt - 7'h01;
        else if (bit_idx == 4'h0)
        begin
          // Continuous: the next sample follows at once
          next_state = adcsc_pkg::ADCSC_SAMPLE;
          next_cnt   = {bit_cyc(converter_mode_reg.speed), 1'b0} - 7'h01;
        end
        else
        begin
          next_bit_idx = bit_idx - 4'h1;
          next_dac     = (cmp_in ? dac_code : dac_code & ~(10'h001 << bit_idx))
                         | (10'h001 << (bit_idx - 4'h1));
          next_cnt     = {1'b0, bit_cyc(converter_mode_reg.speed)} - 7'h01;
        end
      default:
        next_state = adcsc_pkg::ADCSC_IDLE;
    endcase
    // Control rewrite restarts sampling on the new setting
    if (ctl_wr && state != adcsc_pkg::ADCSC_IDLE &&
        state != adcsc_pkg::ADCSC_DELAY)
    begin
      next_state = adcsc_pkg::ADCSC_SAMPLE;
      next_cnt   = {bit_cyc(next_mode.speed), 1'b0} - 7'h01;
    end
    if (!converter_mode_reg.start)
      next_state = adcsc_pkg::ADCSC_IDLE;
    next_sample = next_state == adcsc_pkg::ADCSC_SAMPLE;
  end

  // Sequencer registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state       <= adcsc_pkg::ADCSC_IDLE;
      cnt         <= 7'h00;
      bit_idx     <= 4'h0;
      dac_code    <= 10'h000;
      sample_en   <= 1'b0;
      settle_cnt  <= 11'h000;
      early_start <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      cnt         <= next_cnt;
      bit_idx     <= next_bit_idx;
      dac_code    <= next_dac;
      sample_en   <= next_sample;
      settle_cnt  <= next_settle_cnt;
      early_start <= next_early_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result commit and interrupts; a set beats a same-cycle clear
  always_comb
  begin
    next_pend      = pend;
    next_result    = conv_result_reg;
    next_res_early = res_early;
    next_irq_stat  = irq_stat;
    next_cei       = 1'b0;
    if (commit)
    begin
      next_pend.valid = 1'b0;
      next_result     = pend.data;
      next_res_early  = pend.early;
      next_cei        = 1'b1;
    end
    // A control write at the very end drops the result
    if (done_evt && !ctl_wr)
      next_pend = '{valid: 1'b1, early: early_start, data: done_code};
    if (wr_fire && aw_addr == `ADCSC_OFF_IRQ_CLR && s_axi_wstrb[0])
      next_irq_stat = irq_stat & ~w_data[1:0];
    if (commit)
      next_irq_stat[`ADCSC_IRQ_END_BIT] = 1'b1;
    if (state == adcsc_pkg::ADCSC_IDLE && next_state ==
        adcsc_pkg::ADCSC_DELAY && next_early_start)
      next_irq_stat[`ADCSC_IRQ_EARLY_BIT] = 1'b1;
    next_irq = |(next_irq_stat & next_irq_en);
  end

  // Result and interrupt registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pend               <= '0;
      conv_result_reg    <= 10'h000;
      res_early          <= 1'b0;
      irq_stat           <= 2'h0;
      conv_end_interrupt <= 1'b0;
      irq                <= 1'b0;
      chan_sel           <= `ADCSC_CHSEL_RST;
    end
    else
    begin
      pend               <= next_pend;
      conv_result_reg    <= next_result;
      res_early          <= next_res_early;
      irq_stat           <= next_irq_stat;
      conv_end_interrupt <= next_cei;
      irq                <= next_irq;
      chan_sel           <= next_chsel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [6:0] samp_len;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      samp_len <= 7'h00;
    else
      samp_len <= sample_en ? samp_len + 7'h01 : 7'h00;
  end

  sequence s_no_sample;
    !sample_en [*8];
  endsequence
  sequence s_end_seen;
    conv_end_interrupt && irq_stat[`ADCSC_IRQ_END_BIT];
  endsequence

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chsel_keeps_flag_a: assert property (
    ctl_wr && irq_stat[0] && !(wr_fire && aw_addr == `ADCSC_OFF_IRQ_CLR)
    |=> irq_stat[0])
    else $error("End flag lost on control write");
  old_result_lands_a: assert property (
    done_evt && !ctl_wr && !res_rd_busy ##1 !res_rd_busy |=> s_end_seen)
    else $error("Pre-rewrite result not stored");
  read_first_a: assert property (
    pend.valid && res_rd_busy |=> $stable(conv_result_reg))
    else $error("Result changed under a read");
  end_suppress_a: assert property (
    done_evt && ctl_wr && !pend.valid |=> !pend.valid ##1 !conv_end_interrupt)
    else $error("Suppressed end still stored");
  commit_same_a: assert property (
    commit |=> s_end_seen and (conv_result_reg == $past(pend.data)))
    else $error("Store, flag and interrupt split");
  start_delay_a: assert property (
    state == adcsc_pkg::ADCSC_IDLE && next_state == adcsc_pkg::ADCSC_DELAY
    |=> s_no_sample ##[1:12] sample_en)
    else $error("Start delay wrong");
  sample_len_a: assert property (
    $fell(sample_en) && state == adcsc_pkg::ADCSC_CONVERT && $past(!ctl_wr)
    |-> samp_len == {bit_cyc(converter_mode_reg.speed), 1'b0})
    else $error("Sampling not one sixth");
  early_flag_a: assert property (
    state == adcsc_pkg::ADCSC_IDLE && converter_mode_reg.start &&
    !converter_mode_reg.enable |=> irq_stat[`ADCSC_IRQ_EARLY_BIT])
    else $error("Early start not flagged");

endmodule // adcsc_top

// ==== tb_top.sv ====
`timescale 1ns/10ps
`include "adcsc_consts.svh"
module tb_top;
  logic        core_clk;
  logic        rst;
  logic [5:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [5:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        cmp_in;
  logic [1:0]  chan_sel;
  logic        sample_en;
  logic [9:0]  dac_code;
  logic        conv_end_interrupt;
  logic        irq;
  int          fails;
  int          compares;
  int          run_len;
  int          last_len;
  logic [31:0] rd;

  ////////////////////////////////////////////////////////////////////////////
  // Device under test
  adcsc_top adcsc_top_i
  (
    .core_clk           (core_clk),
    .rst                (rst),
    .s_axi_awaddr       (s_axi_awaddr),
    .s_axi_awvalid      (s_axi_awvalid),
    .s_axi_awready      (s_axi_awready),
    .s_axi_wdata        (s_axi_wdata),
    .s_axi_wstrb        (4'hf),
    .s_axi_wvalid       (s_axi_wvalid),
    .s_axi_wready       (s_axi_wready),
    .s_axi_bresp        (s_axi_bresp),
    .s_axi_bvalid       (s_axi_bvalid),
    .s_axi_bready       (s_axi_bready),
    .s_axi_araddr       (s_axi_araddr),
    .s_axi_arvalid      (s_axi_arvalid),
    .s_axi_arready      (s_axi_arready),
    .s_axi_rdata        (s_axi_rdata),
    .s_axi_rresp        (s_axi_rresp),
    .s_axi_rvalid       (s_axi_rvalid),
    .s_axi_rready       (s_axi_rready),
    .cmp_in             (cmp_in),
    .chan_sel           (chan_sel),
    .sample_en          (sample_en),
    .dac_code           (dac_code),
    .conv_end_interrupt (conv_end_interrupt),
    .irq                (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 125 MHz
  always #4 core_clk = ~core_clk;

  // Length of the last finished sampling phase, in cycles
  always @(posedge core_clk)
  begin
    if (sample_en === 1'b1)
      run_len = run_len + 1;
    else if (run_len != 0)
    begin
      last_len = run_len;
      run_len  = 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison helper
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  // Address and data are offered together, each dropped once taken
  task automatic axi_write(input logic [5:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      n = n + 1;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    chk("write answer", 32'h4, {29'h0, s_axi_bvalid, s_axi_bresp});
  end
  endtask

  // Data is taken at the edge where rvalid is seen with rready high
  task automatic axi_read(input logic [5:0] a, output logic [31:0] d);
    int n;
  begin
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      n = n + 1;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    d = s_axi_rdata;
    chk("read answer", 32'h4, {29'h0, s_axi_rvalid, s_axi_rresp});
  end
  endtask

  task automatic rd_chk(input string what, input logic [5:0] a,
                        input logic [31:0] exp);
  begin
    axi_read(a, rd);
    chk(what, exp, rd);
  end
  endtask

  // Bounded wait for the conversion-end pulse
  task automatic wait_end();
    int n;
  begin
    n = 0;
    do
    begin
      @(posedge core_clk);
      n = n + 1;
    end while (conv_end_interrupt !== 1'b1 && n < 2000);
    chk("end pulse", 32'h1, {31'h0, conv_end_interrupt});
  end
  endtask

  task automatic print_verdict();
  begin
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, well beyond the roughly 2300 cycles the tests need
  initial
  begin
    #400000;
    fails = fails + 1;
    $display("watchdog expired");
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    s_axi_awaddr = 6'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1; // Held high so back-to-back calls never toggle it
    s_axi_araddr = 6'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    cmp_in = 1'b0;
    fails = 0;
    compares = 0;
    run_len = 0;
    last_len = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);

    // Reset values and an unmapped place
    rd_chk("mode", `ADCSC_OFF_MODE, 32'h0);
    rd_chk("chsel", `ADCSC_OFF_CHSEL, 32'h0);
    rd_chk("irq stat", `ADCSC_OFF_IRQ_STAT, 32'h0);
    rd_chk("irq en", `ADCSC_OFF_IRQ_EN, 32'h0);
    rd_chk("unmapped", 6'h1c, 32'h0);
    $display("test reset done");

    // Enable and start together: early first result, speed 0
    axi_write(`ADCSC_OFF_IRQ_EN, 32'h1);
    axi_write(`ADCSC_OFF_CHSEL, 32'h1);
    cmp_in <= 1'b1;
    axi_write(`ADCSC_OFF_MODE, 32'h3);
    wait_end();
    chk("sample len s0", 32'd8, last_len);
    chk("dac code", 32'h3ff, {22'h0, dac_code});
    rd_chk("result", `ADCSC_OFF_RESULT, 32'h3ff);
    axi_write(`ADCSC_OFF_MODE, 32'h1);
    rd_chk("early stat", `ADCSC_OFF_IRQ_STAT, 32'h3);
    chk("irq level", 32'h1, {31'h0, irq});
    rd_chk("hist ch1", 6'h24, 32'h3ff);
    $display("test early start done");

    // Channel rewrite keeps the end flag
    axi_write(`ADCSC_OFF_CHSEL, 32'h2);
    chk("chan sel", 32'h2, {30'h0, chan_sel});
    rd_chk("flag kept", `ADCSC_OFF_IRQ_STAT, 32'h3);
    $display("test channel rewrite done");

    // Clear before resuming
    axi_write(`ADCSC_OFF_IRQ_CLR, 32'h3);
    rd_chk("cleared", `ADCSC_OFF_IRQ_STAT, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("irq low", 32'h0, {31'h0, irq});
    $display("test clear done");

    // Settled start at speed 1: longer sampling, no early flag
    repeat (1800) @(posedge core_clk);
    cmp_in <= 1'b0;
    axi_write(`ADCSC_OFF_MODE, 32'h7);
    wait_end();
    chk("sample len s1", 32'd16, last_len);
    chk("dac low", 32'h1, {22'h0, dac_code});
    rd_chk("result zero", `ADCSC_OFF_RESULT, 32'h0);
    axi_write(`ADCSC_OFF_MODE, 32'h5);
    rd_chk("settled stat", `ADCSC_OFF_IRQ_STAT, 32'h1);
    rd_chk("hist ch2", 6'h28, 32'h0);
    rd_chk("status idle", `ADCSC_OFF_STATUS, 32'h4);
    $display("test settled start done");

    // Result reads back to back hold off the new store
    cmp_in <= 1'b1;
    axi_write(`ADCSC_OFF_MODE, 32'h3);
    repeat (40) rd_chk("result held", `ADCSC_OFF_RESULT, 32'h0);
    wait_end();
    rd_chk("result late", `ADCSC_OFF_RESULT, 32'h3ff);
    axi_write(`ADCSC_OFF_MODE, 32'h1);
    $display("test read priority done");

    // Start with the converter disabled flags the first result
    axi_write(`ADCSC_OFF_IRQ_CLR, 32'h3);
    axi_write(`ADCSC_OFF_MODE, 32'h2);
    wait_end();
    rd_chk("result off", `ADCSC_OFF_RESULT, 32'h3ff);
    axi_write(`ADCSC_OFF_MODE, 32'h0);
    rd_chk("disabled stat", `ADCSC_OFF_IRQ_STAT, 32'h3);
    $display("test disabled start done");

    print_verdict();
  end
endmodule // tb_top
